/* File: hw/mct_regs.svh */
// Constants of the multimode capture timer: field codes and timing counts
`ifndef MCT_REGS_SVH
`define MCT_REGS_SVH

// ----------------------------------------------------------------------
// Mode and control codes
// ----------------------------------------------------------------------
`define MCT_MODE_TIMER   2'h0
`define MCT_MODE_WINDOW  2'h1
`define MCT_MODE_PULSE   2'h2
`define MCT_MODE_PPG     2'h3
`define MCT_START_STOP   2'h0
`define MCT_START_CMD    2'h1
`define MCT_START_RISE   2'h2
`define MCT_START_FALL   2'h3
`define MCT_CLK_EXT      2'h3

// ----------------------------------------------------------------------
// Timing counts (high_freq_clock = ref_clk)
// ----------------------------------------------------------------------
`define MCT_NOISE_REJ_FC 4
`define MCT_NOISE_CYC    3'h5
`define MCT_PRE_W        12
`define MCT_TAP_FAST     3
`define MCT_TAP_MID      7
`define MCT_TAP_SLOW     11
`define MCT_TAP_LOW      3

`endif

/* File: hw/mct_pkg.sv */
// Types shared by the multimode capture timer
package mct_pkg;

   typedef struct packed {
      logic [1:0] operating_mode_sel;
      logic [1:0] source_clock_sel;
      logic [1:0] start_control;
      logic       auto_capture_en;
      logic       capture_edge_sel;
      logic       trigger_stop_sel;
      logic       prescaler_tap_sel;
   } mct_ctrl_t;

   typedef enum logic [1:0] {
      MCT_IDLE = 2'b00,
      MCT_WAIT = 2'b01,
      MCT_RUN  = 2'b11,
      MCT_HOLD = 2'b10
   } mct_state_t;

endpackage

/* File: hw/mct_pin_filter.sv */
// Input pin noise filter and edge detector
`timescale 1ns/1ps
`include "mct_regs.svh"

module mct_pin_filter
   import mct_pkg::*;
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   // Pin and mode
   input  wire logic pin_in,
   input  wire logic bypass,
   // Filtered level and edges
   output logic      level_q,
   output logic      rise_q,
   output logic      fall_q
);

   logic [2:0] stable_cnt_q;
   logic       raw_q;
   logic       new_level;

   // Level is accepted once it outlasts the noise window
   assign new_level = bypass ? raw_q :
                      ((stable_cnt_q == `MCT_NOISE_CYC) ? raw_q : level_q);

   // Count cycles the raw level has stayed unchanged
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         raw_q        <= 1'b0;
         stable_cnt_q <= 3'h0;
         level_q      <= 1'b0;
         rise_q       <= 1'b0;
         fall_q       <= 1'b0;
      end else begin
         raw_q <= pin_in;
         if (pin_in != raw_q)
            stable_cnt_q <= 3'h0;
         else if (stable_cnt_q != `MCT_NOISE_CYC)
            stable_cnt_q <= stable_cnt_q + 3'h1;
         level_q <= new_level;
         rise_q  <= new_level & ~level_q;
         fall_q  <= ~new_level & level_q;
      end
   end

   // Unless bypassed, pulses of four cycles or less never reach the filtered level
   short_pulse_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!bypass && $changed(level_q)) |-> $past(raw_q, 2) == $past(raw_q, 6))
      else $error("Filtered level changed on a short pulse");

endmodule

/* File: hw/mct_prescaler.sv */
// Prescaler giving one-cycle source clock ticks
`timescale 1ns/1ps
`include "mct_regs.svh"

module mct_prescaler
   import mct_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   // Selection
   input  wire logic [1:0] clk_sel,
   input  wire logic       tap_sel,
   input  wire logic       low_speed,
   input  wire logic       low_clk_tick,
   // Tick out
   output logic            tick_q
);

   logic [`MCT_PRE_W-1:0] div_q;
   logic [`MCT_PRE_W-1:0] div_d;
   logic [2:0]            low_div_q;
   logic                  low_tick;
   logic                  fast_tick;
   logic                  mid_tick;
   logic                  slow_tick;
   logic                  sel_tick;

   assign div_d     = div_q + `MCT_PRE_W'(1);
   assign fast_tick = div_d[`MCT_TAP_FAST-1:0] == '0;
   assign mid_tick  = div_d[`MCT_TAP_MID-1:0] == '0;
   assign slow_tick = div_d[`MCT_TAP_SLOW-1:0] == '0;
   assign low_tick  = low_clk_tick && (low_div_q == 3'h7);

   // Source clock selection per low-power state and tap
   assign sel_tick = low_speed ? ((clk_sel == 2'h0) & low_tick) :
                     (clk_sel == 2'h0) ? (tap_sel ? low_tick : slow_tick) :
                     (clk_sel == 2'h1) ? mid_tick :
                     (clk_sel == 2'h2) ? fast_tick : 1'b0;

   // Free-running dividers
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         div_q     <= '0;
         low_div_q <= 3'h0;
         tick_q    <= 1'b0;
      end else begin
         div_q <= div_d;
         if (low_clk_tick)
            low_div_q <= low_div_q + 3'h1;
         tick_q <= sel_tick;
      end
   end

endmodule

/* File: hw/mct_timer.sv */
// Multimode capture timer top: counter, compare, capture and mode control
`timescale 1ns/1ps
`include "mct_regs.svh"

// Functional notes
// - Timer mode counts source ticks; match interrupts, clears, continues.
// - Auto-capture copies running count to capture register in timer/event/window.
// - Capture updates on source ticks; software waits one tick first.
// - Trigger mode holds counter until selected pin edge, then counts ticks.
// - Trigger mode match clears, halts and interrupts.
// - With stop select set, opposite edge before match clears and halts silently.
// - Halted trigger counter restarts from zero on next trigger edge.
// - With stop select clear, opposite and repeated trigger edges ignored.
// - Filter rejects pulses of four fc or less; source holds twelve.
// - Low-speed and sleep bypass the filter; pulses last a machine cycle.
// - Event mode counts selected pin edges; match clears and interrupts.
// - Event mode compares on the edge opposite to counting edge.
// - Window mode counts ticks while pin active; 10 high, 11 low.
// - Single-edge pulse mode: capture, interrupt, set counter to one on opposite edge.
// - Double-edge: capture opposite edge, capture again at trigger and clear.
// - Single-edge counter holds at one after capture until next edge.
// - Source select picks three prescaled clocks or the input pin.
// - Mode select: 00 timer group, 01 window, 10 pulse, 11 generator.
// - Start control 00 stops and clears the counter in every mode.
module mct_timer
   import mct_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // Control fields
   input  wire mct_ctrl_t   timer_control_reg,
   input  wire logic [15:0] compare_limit_reg,
   input  wire logic        low_speed_run_mode,
   input  wire logic        low_speed_sleep_mode,
   input  wire logic        low_freq_clock_tick,
   // External pin
   input  wire logic        timer_input_pin,
   // Results
   output logic [15:0]      capture_reg,
   output logic [15:0]      count_q,
   output logic             match_interrupt
);

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   mct_state_t  state_q;
   mct_state_t  state_d;
   logic [15:0] count_d;
   logic [15:0] cap_d;
   logic        irq_d;
   logic        pin_lvl;
   logic        pin_rise;
   logic        pin_fall;
   logic        src_tick;
   logic        low_speed;
   logic        stopped;
   logic        mode_timer;
   logic        mode_window;
   logic        mode_pulse;
   logic        sel_rise;
   logic        trig_edge;
   logic        opp_edge;
   logic        cnt_edge;
   logic        ext_clk;
   logic        ext_trig;
   logic        event_mode;
   logic        window_active;
   logic        at_limit;
   logic        tick_any;
   logic        auto_cap;

   // ------------------------------------------------------------------
   // Sub-blocks
   // ------------------------------------------------------------------
   assign low_speed = low_speed_run_mode | low_speed_sleep_mode;

   // Input conditioning, bypassed in low-power modes
   mct_pin_filter u_filter (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .pin_in  (timer_input_pin),
      .bypass  (low_speed),
      .level_q (pin_lvl),
      .rise_q  (pin_rise),
      .fall_q  (pin_fall)
   );

   // Prescaled internal source clock
   mct_prescaler u_pre (
      .ref_clk      (ref_clk),
      .sys_rst      (sys_rst),
      .clk_sel      (timer_control_reg.source_clock_sel),
      .tap_sel      (timer_control_reg.prescaler_tap_sel),
      .low_speed    (low_speed),
      .low_clk_tick (low_freq_clock_tick),
      .tick_q       (src_tick)
   );

   // ------------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------------
   assign stopped     = timer_control_reg.start_control == `MCT_START_STOP;
   assign mode_timer  = timer_control_reg.operating_mode_sel == `MCT_MODE_TIMER;
   assign mode_window = timer_control_reg.operating_mode_sel == `MCT_MODE_WINDOW;
   assign mode_pulse  = timer_control_reg.operating_mode_sel == `MCT_MODE_PULSE;
   assign sel_rise    = timer_control_reg.start_control == `MCT_START_RISE;
   assign ext_clk     = timer_control_reg.source_clock_sel == `MCT_CLK_EXT;
   assign trig_edge   = sel_rise ? pin_rise : pin_fall;
   assign opp_edge    = sel_rise ? pin_fall : pin_rise;
   assign event_mode  = mode_timer & ext_clk & ~stopped & 
                        (timer_control_reg.start_control != `MCT_START_CMD);
   assign ext_trig    = mode_timer & ~ext_clk & ~stopped &
                        (timer_control_reg.start_control != `MCT_START_CMD);
   assign cnt_edge    = trig_edge;
   assign window_active = sel_rise ? pin_lvl : ~pin_lvl;
   assign at_limit    = count_q == compare_limit_reg;
   assign tick_any    = ext_clk ? cnt_edge : src_tick;
   assign auto_cap    = timer_control_reg.auto_capture_en & ~mode_pulse &
                        ~stopped & ~ext_trig & (state_q == MCT_RUN) & tick_any;

   // ------------------------------------------------------------------
   // Counter and mode sequencing
   // ------------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      count_d = count_q;
      cap_d   = capture_reg;
      irq_d   = 1'b0;
      if (stopped) begin
         state_d = MCT_IDLE;
         count_d = 16'h0000;
      end else begin
         case (state_q)
            MCT_IDLE: begin
               count_d = 16'h0000;
               if (mode_pulse || ext_trig)
                  state_d = MCT_WAIT;
               else if (!mode_pulse && timer_control_reg.operating_mode_sel != `MCT_MODE_PPG)
                  state_d = MCT_RUN;
            end
            MCT_WAIT: begin
               if (trig_edge) begin
                  state_d = MCT_RUN;
                  count_d = 16'h0000;
               end
            end
            MCT_RUN: begin
               if (mode_pulse) begin
                  if (opp_edge) begin
                     cap_d = count_q;
                     irq_d = 1'b1;
                     if (timer_control_reg.capture_edge_sel) begin
                        count_d = 16'h0001;
                        state_d = MCT_HOLD;
                     end
                  end else if (trig_edge && !timer_control_reg.capture_edge_sel) begin
                     cap_d   = count_q;
                     irq_d   = 1'b1;
                     count_d = 16'h0000;
                  end else if (src_tick) begin
                     count_d = count_q + 16'h0001;
                  end
               end else if (ext_trig) begin
                  if (timer_control_reg.trigger_stop_sel && opp_edge) begin
                     count_d = 16'h0000;
                     state_d = MCT_WAIT;
                  end else if (src_tick && at_limit) begin
                     count_d = 16'h0000;
                     irq_d   = 1'b1;
                     state_d = MCT_WAIT;
                  end else if (src_tick) begin
                     count_d = count_q + 16'h0001;
                  end
               end else if (event_mode) begin
                  if (opp_edge && at_limit) begin
                     count_d = 16'h0000;
                     irq_d   = 1'b1;
                  end else if (cnt_edge) begin
                     count_d = count_q + 16'h0001;
                  end
               end else if (src_tick && (!mode_window || window_active)) begin
                  if (at_limit) begin
                     count_d = 16'h0000;
                     irq_d   = 1'b1;
                  end else begin
                     count_d = count_q + 16'h0001;
                  end
               end
               if (auto_cap)
                  cap_d = count_q;
            end
            MCT_HOLD: begin
               if (trig_edge) begin
                  state_d = MCT_RUN;
               end
            end
            default: begin
               state_d = MCT_IDLE;
            end
         endcase
      end
   end

   // State registers
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_q         <= MCT_IDLE;
         count_q         <= 16'h0000;
         capture_reg     <= 16'h0000;
         match_interrupt <= 1'b0;
      end else begin
         state_q         <= state_d;
         count_q         <= count_d;
         capture_reg     <= cap_d;
         match_interrupt <= irq_d;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   sequence run_at_limit_s;
      state_q == MCT_RUN && mode_timer && !ext_trig && !event_mode && !stopped
      && !ext_clk && src_tick && at_limit;
   endsequence

   timer_wrap_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      run_at_limit_s |=> match_interrupt && count_q == 16'h0000)
      else $error("Timer match did not clear and interrupt");

   irq_pulse_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      match_interrupt |=> !match_interrupt)
      else $error("Interrupt not a single pulse");

   stop_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      stopped |=> count_q == 16'h0000 && !match_interrupt)
      else $error("Stop did not clear counter");

   trig_halt_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state_q == MCT_RUN && ext_trig && src_tick && at_limit &&
       !(timer_control_reg.trigger_stop_sel && opp_edge))
      |=> state_q == MCT_WAIT && match_interrupt)
      else $error("Trigger match did not halt");

   opp_stop_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state_q == MCT_RUN && ext_trig && timer_control_reg.trigger_stop_sel && opp_edge)
      |=> state_q == MCT_WAIT && !match_interrupt && count_q == 16'h0000)
      else $error("Opposite edge did not halt silently");

   wait_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state_q == MCT_WAIT && !trig_edge && !stopped) |=> count_q == $past(count_q))
      else $error("Counter moved while awaiting trigger");

   single_cap_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state_q == MCT_RUN && mode_pulse && opp_edge && !stopped &&
       timer_control_reg.capture_edge_sel)
      |=> capture_reg == $past(count_q) && count_q == 16'h0001 && state_q == MCT_HOLD)
      else $error("Single-edge capture wrong");

   double_cap_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state_q == MCT_RUN && mode_pulse && trig_edge && !opp_edge && !stopped &&
       !timer_control_reg.capture_edge_sel)
      |=> match_interrupt && count_q == 16'h0000)
      else $error("Double-edge cycle capture wrong");

   event_cmp_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state_q == MCT_RUN && event_mode && cnt_edge) |=> !match_interrupt)
      else $error("Event match raised on counting edge");

   window_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state_q == MCT_RUN && mode_window && !stopped && !window_active)
      |=> count_q == $past(count_q))
      else $error("Window counted while inactive");

endmodule

/* File: sim/mct_pin_source.sv */
// Model of the pulse or event source that drives the timer input pin
`timescale 1ns/1ps

module mct_pin_source
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   // Command from the bench
   input  wire logic       go,
   input  wire logic       go_level,
   input  wire logic [9:0] go_hold,
   // Pin and status
   output logic            pin,
   output logic            busy
);
   logic [9:0] hold_q;
   logic       level_q;

   // Take a new level only once the last one has served its hold
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         hold_q  <= 10'h000;
         level_q <= 1'b0;
      end else if (go && hold_q == 10'h000) begin
         hold_q  <= go_hold; // Each level stands its full hold
         level_q <= go_level;
      end else if (hold_q != 10'h000) begin
         hold_q <= hold_q - 10'h001;
      end
   end

   // Pin moves away from the sampling edge
   always @(negedge ref_clk) pin <= level_q;
   assign busy = (hold_q != 10'h000);
endmodule

/* File: sim/mct_timer_bench.sv */
// Self-checking bench of the multimode capture timer
`timescale 1ns/1ps

module mct_timer_bench
   import mct_pkg::*;
();
   logic        ref_clk, sys_rst, lsr, lss, lft, go, go_level, pin, busy, irq, irq_last;
   mct_ctrl_t   ctrl;
   logic [15:0] limit, cap, cnt;
   logic [9:0]  go_hold;
   int          errors, check_count, irq_n, k, m, j;
   time         t0;

   // Design and pin source
   mct_timer mct_timer_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .timer_control_reg(ctrl),
      .compare_limit_reg(limit), .low_speed_run_mode(lsr), .low_speed_sleep_mode(lss),
      .low_freq_clock_tick(lft), .timer_input_pin(pin), .capture_reg(cap), .count_q(cnt),
      .match_interrupt(irq));
   mct_pin_source mct_pin_source_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .go(go),
      .go_level(go_level), .go_hold(go_hold), .pin(pin), .busy(busy));

   // Clock and watchdog
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      #600us;
      errors++;
      results();
   end

   // Random low clock ticks and interrupt pulse monitor
   always @(negedge ref_clk) begin
      lft <= ($urandom_range(15) == 0);
      if (!sys_rst) chk({15'h0, irq & irq_last}, 16'h0000);
      if (irq === 1'b1) irq_n++;
      irq_last = irq;
   end

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function logic [15:0] rng(input logic [15:0] v, input int lo, input int hi);
      return {15'h0, (v >= lo) && (v <= hi)};
   endfunction
   task cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task cfg(input logic [1:0] md, sc, st, input logic ac, ce, ts);
      ctrl.start_control = 2'h0;
      cyc(2);
      chk(cnt, 16'h0000);
      ctrl = '{md, sc, 2'h0, ac, ce, ts, 1'b0};
      cyc(2);
      ctrl.start_control = st;
      m = irq_n;
      cyc(1);
   endtask
   task send(input logic lv, input int h);
      go = 1'b1;
      go_level = lv;
      go_hold = h[9:0];
      cyc(1);
      go = 1'b0;
      for (int i = 0; i < 2000 && busy === 1'b1; i++) cyc(1);
   endtask
   task wirq();
      int base;
      base = irq_n;
      for (int i = 0; i < 10000 && irq_n == base; i++) cyc(1);
   endtask
   task tend(input string s);
      $display("test %s done", s);
   endtask
   task results();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      ctrl = '0;
      limit = 16'h0000;
      {lsr, lss, go, go_level} = 4'h0;
      go_hold = 10'h000;
      {errors, check_count, irq_n} = 0;
      void'($urandom(32'h2b65a353));
      cyc(2);
      sys_rst = 1'b0;
      cyc(1);
      chk(cap, 16'h0000);
      // Interval timer on each internal source
      for (k = 0; k < 3; k++) begin
         limit = 16'($urandom_range(3, 2));
         cfg(2'h0, 2'(2 - k), 2'h1, 1'b1, 1'b0, 1'b0);
         wirq();
         t0 = $time;
         wirq();
         chk(16'(($time - t0) / 10), 16'((limit + 1) * (8 << (4 * k))));
         cyc(2 * (8 << (4 * k)) + 4);
         chk(rng(cap, 1, 2), 16'h0001);
      end
      tend("timer");
      // Event counter, filter and bypass
      limit = 16'($urandom_range(4, 2));
      cfg(2'h0, 2'h3, 2'h2, 1'b0, 1'b0, 1'b0);
      send(1'b1, 4);
      send(1'b0, 30);
      chk(cnt, 16'h0000);
      for (j = 1; j <= limit; j++) begin
         send(1'b1, 12);
         cyc(10);
         chk(cnt, 16'(j));
         chk(16'(irq_n - m), 16'h0000);
         send(1'b0, 20);
         cyc(10);
         chk(cnt, (j == limit) ? 16'h0000 : 16'(j));
         chk(16'(irq_n - m), 16'(j == limit));
      end
      lsr = 1'b1;
      send(1'b1, 4);
      send(1'b0, 30);
      chk(cnt, 16'h0001);
      lsr = 1'b0;
      tend("event");
      // Window counting, both polarities
      limit = 16'hFFFF;
      for (j = 2; j < 4; j++) begin
         send(j == 3, 40);
         cfg(2'h1, 2'h2, 2'(j), 1'b0, 1'b0, 1'b0);
         cyc(20);
         chk(cnt, 16'h0000);
         send(j == 2, 80);
         chk(rng(cnt, 8, 11), 16'h0001);
         send(j == 3, 30);
         k = cnt;
         cyc(40);
         chk(cnt, 16'(k));
      end
      tend("window");
      // External trigger with stop on opposite edge
      send(1'b0, 30);
      limit = 16'h0064;
      cfg(2'h0, 2'h2, 2'h2, 1'b0, 1'b0, 1'b1);
      cyc(30);
      chk(cnt, 16'h0000);
      send(1'b1, 40);
      chk(rng(cnt, 2, 6), 16'h0001);
      send(1'b0, 30);
      chk(cnt, 16'h0000);
      chk(16'(irq_n - m), 16'h0000);
      send(1'b1, 900);
      chk(16'(irq_n - m), 16'h0001);
      chk(cnt, 16'h0000);
      // External trigger, opposite edge ignored
      send(1'b0, 30);
      limit = 16'h000A;
      cfg(2'h0, 2'h2, 2'h2, 1'b0, 1'b0, 1'b0);
      send(1'b1, 30);
      send(1'b0, 150);
      chk(16'(irq_n - m), 16'h0001);
      chk(cnt, 16'h0000);
      tend("trigger");
      // Pulse width, single edge then double edge
      limit = 16'hFFFF;
      k = $urandom_range(12, 6);
      cfg(2'h2, 2'h2, 2'h2, 1'b0, 1'b1, 1'b0);
      for (j = 1; j < 3; j++) begin
         send(1'b1, 8 * k);
         send(1'b0, 60);
         chk(16'(irq_n - m), 16'(j));
         chk(rng(cap, k - 2 + j, k + j), 16'h0001);
         chk(cnt, 16'h0001);
      end
      cfg(2'h2, 2'h2, 2'h2, 1'b0, 1'b0, 1'b0);
      send(1'b1, 8 * k);
      send(1'b0, 80);
      chk(16'(irq_n - m), 16'h0001);
      chk(rng(cap, k - 1, k + 1), 16'h0001);
      send(1'b1, 40);
      chk(16'(irq_n - m), 16'h0002);
      chk(rng(cap, k + 9, k + 11), 16'h0001);
      chk(rng(cnt, 2, 6), 16'h0001);
      tend("pulse");
      // Generator code must leave the counter idle here
      cfg(2'h3, 2'h2, 2'h1, 1'b0, 1'b0, 1'b0);
      cyc(40);
      chk(cnt, 16'h0000);
      tend("generator");
      results();
   end
endmodule
